/* logic/lbrg_cpu_end.sv */
// processor end: two request/grant lines with priority and bus float control
`timescale 1ns/1ps
module lbrg_cpu_end (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // link
   lbrg_if.cpu             link,
   // bus interface unit state
   input  wire logic       bus_busy,
   input  wire logic       eu_pending,
   input  wire logic       xfer_req,
   input  wire logic [2:0] status_in,
   input  wire logic       lock_in_n,
   // ownership report
   output logic [1:0]      line_granted
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   lbrg_pkg::lbrg_cpu_state_t state_reg, state_next;
   logic [1:0] oe_reg, oe_next;
   logic [1:0] pend_reg, pend_next;
   logic       owner_reg, owner_next;
   logic [1:0] cnt_reg, cnt_next;
   logic       stat_float_reg, stat_float_next;
   logic       stat_oe_reg;
   logic       ad_oe_reg;
   logic       go_float;
   logic [1:0] granted_reg, granted_next;
   logic [2:0] status_reg;
   logic       lock_n_reg;
   // last count of the redrive wait
   localparam logic [1:0] REDRIVE_LAST_C = lbrg_pkg::REDRIVE_LAST;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   // a low line this end is not pulling is the other side's pulse
   wire [1:0] pulse_seen  = ~link.bus_handoff_line & ~oe_reg;
   wire       owner_rel   = pulse_seen[owner_reg];
   wire [1:0] pend_all    = pend_reg | pulse_seen;
   // line 0 wins whenever both wait unanswered
   wire       sel_line    = ~pend_all[0];
   wire       any_pend    = |pend_all;
   wire       other_line  = ~owner_reg;
   wire       other_pend  = pend_reg[other_line];
   wire       can_grant   = any_pend & ~bus_busy;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      state_next      = state_reg;
      oe_next         = 2'h0;
      pend_next       = pend_reg;
      owner_next      = owner_reg;
      cnt_next        = cnt_reg;
      stat_float_next = stat_float_reg;
      granted_next    = granted_reg;
      go_float        = 1'b0;
      case (state_reg)
         lbrg_pkg::CPU_OWN, lbrg_pkg::CPU_REDRIVE: begin
            pend_next = pend_all;
            if (state_reg == lbrg_pkg::CPU_REDRIVE && cnt_reg != REDRIVE_LAST_C) begin
               cnt_next = cnt_reg + 2'h1;
            end
            if (can_grant) begin
               // grant pulse in the cycle after the request, or after bus_busy clears for a queued one
               oe_next[sel_line]    = 1'b1;
               pend_next[sel_line]  = 1'b0;
               owner_next           = sel_line;
               granted_next         = 2'h0;
               granted_next[sel_line] = 1'b1;
               state_next           = lbrg_pkg::CPU_GRANT;
            end else if (state_reg == lbrg_pkg::CPU_REDRIVE && cnt_reg == REDRIVE_LAST_C
                         && xfer_req) begin
               // bus stays undriven until a transfer is wanted
               stat_float_next = 1'b0;
               state_next      = lbrg_pkg::CPU_OWN;
            end
         end
         lbrg_pkg::CPU_GRANT: begin
            // float on the cycle after the grant pulse
            go_float        = 1'b1;
            stat_float_next = 1'b1;
            pend_next       = pend_reg | (pulse_seen & ~(2'h1 << owner_reg));
            state_next      = lbrg_pkg::CPU_AWAY;
         end
         lbrg_pkg::CPU_AWAY: begin
            // requests on the other line only queue up
            pend_next = pend_reg | (pulse_seen & ~(2'h1 << owner_reg));
            if (owner_rel) begin
               granted_next = 2'h0;
               if (pend_next[other_line] && owner_reg && eu_pending) begin
                  state_next = lbrg_pkg::CPU_HANDOFF;
               end else if (pend_next[other_line]) begin
                  oe_next[other_line]    = 1'b1;
                  pend_next[other_line]  = 1'b0;
                  owner_next             = other_line;
                  granted_next[other_line] = 1'b1;
                  state_next             = lbrg_pkg::CPU_GRANT;
               end else begin
                  cnt_next   = 2'h0;
                  state_next = lbrg_pkg::CPU_REDRIVE;
               end
            end
         end
         lbrg_pkg::CPU_HANDOFF: begin
            // second clock of a slow line 1 to line 0 handoff
            pend_next                = pend_all;
            oe_next[other_line]      = 1'b1;
            pend_next[other_line]    = 1'b0;
            owner_next               = other_line;
            granted_next[other_line] = 1'b1;
            state_next               = lbrg_pkg::CPU_GRANT;
         end
         default: begin
            state_next = lbrg_pkg::CPU_OWN;
         end
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg      <= lbrg_pkg::CPU_OWN;
         oe_reg         <= 2'h0;
         pend_reg       <= 2'h0;
         owner_reg      <= 1'b0;
         cnt_reg        <= 2'h0;
         stat_float_reg <= 1'b0;
         stat_oe_reg    <= 1'b1;
         granted_reg    <= 2'h0;
      end else begin
         state_reg      <= state_next;
         oe_reg         <= oe_next;
         pend_reg       <= pend_next;
         owner_reg      <= owner_next;
         cnt_reg        <= cnt_next;
         stat_float_reg <= stat_float_next;
         stat_oe_reg    <= ~stat_float_next;
         granted_reg    <= granted_next;
      end
   end

   // address/data follows status by one clock on redrive
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ad_oe_reg <= 1'b1;
      end else begin
         ad_oe_reg <= ~(go_float | stat_float_reg);
      end
   end

   // status and lock copies put on the local bus
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_reg <= lbrg_pkg::STATUS_IDLE;
         lock_n_reg <= lbrg_pkg::LOCK_INACTIVE;
      end else begin
         status_reg <= status_in;
         lock_n_reg <= lock_in_n;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign link.cpu_line_oe   = oe_reg;
   assign link.cpu_status    = status_reg;
   assign link.cpu_lock_n    = lock_n_reg;
   assign link.cpu_status_oe = stat_oe_reg;
   assign link.cpu_ad_oe     = ad_oe_reg;
   assign line_granted       = granted_reg;
endmodule : lbrg_cpu_end

/* logic/lbrg_if.sv */
// interface joining the processor end and the alternate master end
`timescale 1ns/1ps
interface lbrg_if;
   // ------------------------------------------------------------
   // handoff lines: open drain, low while either side drives
   // ------------------------------------------------------------
   logic [1:0] cpu_line_oe;
   logic [1:0] mst_line_oe;
   logic [1:0] bus_handoff_line;
   // processor status, lock and bus enables
   logic [2:0] cpu_status;
   logic       cpu_lock_n;
   logic       cpu_status_oe;
   logic       cpu_ad_oe;
   logic [2:0] cycle_status;
   logic       lock_lvl_n;
   // master drive of the local bus
   logic       mst_bus_oe;

   // pull-ups give idle status and inactive lock while floated
   assign bus_handoff_line = ~(cpu_line_oe | mst_line_oe);
   assign cycle_status     = cpu_status_oe ? cpu_status : lbrg_pkg::STATUS_IDLE;
   assign lock_lvl_n       = cpu_status_oe ? cpu_lock_n : lbrg_pkg::LOCK_INACTIVE;

   modport cpu (
      input  bus_handoff_line,
      output cpu_line_oe,
      output cpu_status,
      output cpu_lock_n,
      output cpu_status_oe,
      output cpu_ad_oe
   );
   modport mst (
      input  bus_handoff_line,
      input  cycle_status,
      input  lock_lvl_n,
      output mst_line_oe,
      output mst_bus_oe
   );
endinterface : lbrg_if

/* logic/lbrg_mst_end.sv */
// alternate master end: hold/acknowledge converter and hold isolation arbiter
`timescale 1ns/1ps
module lbrg_mst_end #(
   parameter int LINE = 0
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // link
   lbrg_if.mst       link,
   // user side
   input  wire logic hold_req,
   input  wire logic iso_mode,
   output logic      bus_hold_acknowledge,
   output logic      bus_drive,
   output logic      cmd_disable,
   output logic      bus_isolate_enable,
   output logic      ready_enable
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   lbrg_pkg::lbrg_mst_state_t state_reg, state_next;
   logic       oe_reg, oe_next;
   logic       ack_reg, ack_next;
   logic       drive_reg, drive_next;
   logic       cmd_dis_reg, cmd_dis_next;
   logic       iso_reg, iso_next;
   logic       rdy_reg;
   logic [1:0] rdy_cnt_reg;

   // grant is a low level while this end is not pulling
   wire grant_seen = ~link.bus_handoff_line[LINE] & ~oe_reg;
   // idle status and no lock mark a safe point to isolate
   wire safe_point = (link.cycle_status == lbrg_pkg::STATUS_IDLE)
                     & (link.lock_lvl_n == lbrg_pkg::LOCK_INACTIVE);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      state_next   = state_reg;
      oe_next      = 1'b0;
      ack_next     = ack_reg;
      drive_next   = drive_reg;
      cmd_dis_next = cmd_dis_reg;
      iso_next     = iso_reg;
      case (state_reg)
         lbrg_pkg::M_IDLE: begin
            if (hold_req && !iso_mode) begin
               oe_next    = 1'b1;
               state_next = lbrg_pkg::M_REQ;
            end else if (hold_req && safe_point) begin
               iso_next   = 1'b1;
               cmd_dis_next = 1'b1;
               ack_next   = 1'b1;
               state_next = lbrg_pkg::M_ISO;
            end
         end
         lbrg_pkg::M_REQ: begin
            state_next = lbrg_pkg::M_WAIT;
         end
         lbrg_pkg::M_WAIT: begin
            if (grant_seen) begin
               cmd_dis_next = 1'b1;
               state_next   = lbrg_pkg::M_FLOAT;
            end
         end
         lbrg_pkg::M_FLOAT: begin
            // one clock for the processor to float first
            drive_next = 1'b1;
            ack_next   = 1'b1;
            state_next = lbrg_pkg::M_OWN;
         end
         lbrg_pkg::M_OWN: begin
            if (!hold_req) begin
               drive_next = 1'b0;
               state_next = lbrg_pkg::M_STOP;
            end
         end
         lbrg_pkg::M_STOP: begin
            oe_next    = 1'b1;
            ack_next   = 1'b0;
            state_next = lbrg_pkg::M_REL;
         end
         lbrg_pkg::M_REL: begin
            cmd_dis_next = 1'b0;
            state_next   = lbrg_pkg::M_IDLE;
         end
         lbrg_pkg::M_ISO: begin
            if (!hold_req) begin
               iso_next   = 1'b0;
               cmd_dis_next = 1'b0;
               ack_next   = 1'b0;
               state_next = lbrg_pkg::M_IDLE;
            end
         end
         default: begin
            state_next = lbrg_pkg::M_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg   <= lbrg_pkg::M_IDLE;
         oe_reg      <= 1'b0;
         ack_reg     <= 1'b0;
         drive_reg   <= 1'b0;
         cmd_dis_reg <= 1'b0;
         iso_reg     <= 1'b0;
      end else begin
         state_reg   <= state_next;
         oe_reg      <= oe_next;
         ack_reg     <= ack_next;
         drive_reg   <= drive_next;
         cmd_dis_reg <= cmd_dis_next;
         iso_reg     <= iso_next;
      end
   end

   // ready detection returns two clocks after isolation ends
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdy_reg     <= 1'b1;
         rdy_cnt_reg <= 2'h0;
      end else if (iso_reg) begin
         rdy_reg     <= 1'b0;
         rdy_cnt_reg <= 2'h0;
      end else if (!rdy_reg) begin
         rdy_cnt_reg <= rdy_cnt_reg + 2'h1;
         rdy_reg     <= (rdy_cnt_reg == lbrg_pkg::READY_LAST);
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign link.mst_line_oe       = 2'(oe_reg) << LINE;
   assign link.mst_bus_oe        = drive_reg;
   assign bus_hold_acknowledge   = ack_reg;
   assign bus_drive              = drive_reg;
   assign cmd_disable            = cmd_dis_reg;
   assign bus_isolate_enable     = iso_reg;
   assign ready_enable           = rdy_reg;
endmodule : lbrg_mst_end

/* logic/lbrg_pkg.sv */
// shared constants and types for the local bus request/grant ends
package lbrg_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS   = 50;
   localparam int REDRIVE_CLOCKS    = 3;
   localparam int READY_PERIODS     = 2;
   localparam logic [1:0] REDRIVE_LAST = 2'(REDRIVE_CLOCKS - 1);
   localparam logic [1:0] READY_LAST   = 2'(READY_PERIODS - 1);

   // ------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------
   localparam logic [2:0] STATUS_IDLE    = 3'h7;
   localparam logic       LOCK_INACTIVE  = 1'h1;

   // ------------------------------------------------------------
   // state machines
   // ------------------------------------------------------------
   typedef enum logic [2:0] {CPU_OWN, CPU_GRANT, CPU_AWAY, CPU_HANDOFF, CPU_REDRIVE}
      lbrg_cpu_state_t;
   typedef enum logic [2:0] {M_IDLE, M_REQ, M_WAIT, M_FLOAT, M_OWN, M_STOP, M_REL, M_ISO}
      lbrg_mst_state_t;
endpackage : lbrg_pkg

/* tb/lbrg_properties.sv */
// assertions on the request/grant link between the processor and master ends
`timescale 1ns/1ps
module lbrg_properties (
   // clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // link signals
   input wire logic [1:0] cpu_line_oe,
   input wire logic [1:0] mst_line_oe,
   input wire logic       cpu_status_oe,
   input wire logic       cpu_ad_oe,
   input wire logic       mst_bus_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // ------------------------------------------------------------
   // handoff steps
   // ------------------------------------------------------------
   sequence s_grant;
      cpu_line_oe[0] ##1 !cpu_line_oe[0];
   endsequence
   sequence s_float;
      !cpu_status_oe && !cpu_ad_oe;
   endsequence

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   chk_pulse_one_clock: assert property (mst_line_oe[0] |=> !mst_line_oe[0])
      else $error("master pulse longer than one clock");
   chk_idle_grant_next: assert property (
      mst_line_oe[0] && !cpu_line_oe[0] && cpu_status_oe |=> s_grant)
      else $error("idle request not granted on the next edge");
   chk_grant_one_clock: assert property (cpu_line_oe[0] |=> !cpu_line_oe[0])
      else $error("grant pulse longer than one clock");
   chk_float_after_grant: assert property ($fell(cpu_line_oe[0]) |=> s_float)
      else $error("bus not floated after grant");
   chk_no_contention: assert property (
      mst_bus_oe |-> !cpu_status_oe && !cpu_ad_oe)
      else $error("both ends drive the local bus");
   chk_master_waits_float: assert property ($rose(mst_bus_oe) |-> $past(!cpu_ad_oe))
      else $error("master drove before the processor floated");
   chk_redrive_delay: assert property (
      mst_line_oe[0] && !cpu_status_oe |=> !cpu_status_oe [*2])
      else $error("status redriven too early after release");
   chk_ad_after_status: assert property (
      $rose(cpu_status_oe) |-> !cpu_ad_oe ##1 cpu_ad_oe)
      else $error("bus redrive not one clock after status");
   cov_handoff: cover property (s_grant ##[1:20] $rose(cpu_status_oe));
endmodule : lbrg_properties

/* tb/local_bus_request_grant_tb.sv */
// self-checking bench for the processor and master request/grant ends
`timescale 1ns/1ps
module local_bus_request_grant_tb;
   // ------------------------------------------------------------
   // bench state
   // ------------------------------------------------------------
   logic       clk        = 1'b0;
   logic       sys_rst    = 1'b1;
   logic       hold_req   = 1'b0;
   logic       iso_mode   = 1'b0;
   logic       bus_busy   = 1'b0;
   logic       eu_pending = 1'b0;
   logic       xfer_req   = 1'b1;
   logic [2:0] status_in  = 3'h7;
   logic       lock_in_n  = 1'b1;
   logic [1:0] b_req_oe   = 2'h0;
   logic [1:0] grant_a;
   logic [1:0] grant_b;
   logic       ack, drive, cmd_dis, iso, rdy;
   int         err_total   = 0;
   int         comparisons = 0;
   int         n;

   // clock
   always #25 clk = ~clk;

   // link a joins the processor and master ends, link b joins a second processor end to bench-driven request lines
   lbrg_if a_if ();
   lbrg_if b_if ();
   assign b_if.mst_line_oe = b_req_oe;
   assign b_if.mst_bus_oe  = 1'b0;

   // design ends and checker
   lbrg_cpu_end lbrg_cpu_end_inst (.clk(clk), .sys_rst(sys_rst), .link(a_if.cpu),
      .bus_busy(bus_busy), .eu_pending(eu_pending), .xfer_req(xfer_req),
      .status_in(status_in), .lock_in_n(lock_in_n), .line_granted(grant_a));
   lbrg_cpu_end lbrg_cpu_end_inst2 (.clk(clk), .sys_rst(sys_rst), .link(b_if.cpu),
      .bus_busy(bus_busy), .eu_pending(eu_pending), .xfer_req(xfer_req),
      .status_in(status_in), .lock_in_n(lock_in_n), .line_granted(grant_b));
   lbrg_mst_end #(.LINE(0)) lbrg_mst_end_inst (.clk(clk), .sys_rst(sys_rst),
      .link(a_if.mst), .hold_req(hold_req), .iso_mode(iso_mode),
      .bus_hold_acknowledge(ack), .bus_drive(drive), .cmd_disable(cmd_dis),
      .bus_isolate_enable(iso), .ready_enable(rdy));
   lbrg_properties lbrg_properties_inst (.clk(clk), .sys_rst(sys_rst),
      .cpu_line_oe(a_if.cpu_line_oe), .mst_line_oe(a_if.mst_line_oe),
      .cpu_status_oe(a_if.cpu_status_oe), .cpu_ad_oe(a_if.cpu_ad_oe),
      .mst_bus_oe(a_if.mst_bus_oe));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   // one bounded polling step; a spent bound ends the run
   task automatic bound(input string what);
      n++;
      if (n > 20) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, 8'h1, 8'h0);
         tally_and_finish();
      end else begin
         tick(1);
      end
   endtask : bound

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_reset();
      check("status oe", 8'h1, a_if.cpu_status_oe);
      check("ad oe", 8'h1, a_if.cpu_ad_oe);
      check("status idle", 8'h7, a_if.cycle_status);
      check("line oe", 8'h0, {a_if.cpu_line_oe, a_if.mst_line_oe});
      check("owner", 8'h0, grant_a);
      check("master outputs", 8'h0, {ack, drive, cmd_dis, iso});
      check("ready", 8'h1, rdy);
      $display("test reset done");
   endtask : test_reset

   task automatic test_handoff();
      @(posedge clk);
      xfer_req  <= 1'b0;
      hold_req  <= 1'b1;
      lock_in_n <= 1'b0;
      status_in <= 3'h4;
      n = 0;
      while (drive !== 1'b1) bound("bus drive");
      check("owner", 8'h1, grant_a);
      check("ack", 8'h1, ack);
      check("cmd disable", 8'h1, cmd_dis);
      check("ad oe", 8'h0, a_if.cpu_ad_oe);
      check("lock floated", 8'h1, a_if.lock_lvl_n);
      check("status floated", 8'h7, a_if.cycle_status);
      @(posedge clk);
      hold_req <= 1'b0;
      tick(1);
      check("drive off", 8'h0, drive);
      tick(1);
      check("ack off", 8'h0, ack);
      check("release pulse", 8'h1, a_if.mst_line_oe);
      tick(6);
      check("stays floated", 8'h0, a_if.cpu_status_oe);
      check("cmd enabled", 8'h0, cmd_dis);
      check("owner", 8'h0, grant_a);
      @(posedge clk);
      xfer_req <= 1'b1;
      n = 0;
      while (a_if.cpu_status_oe !== 1'b1) bound("status redrive");
      check("ad waits", 8'h0, a_if.cpu_ad_oe);
      check("status redriven", 8'h4, a_if.cycle_status);
      tick(1);
      check("ad redrive", 8'h1, a_if.cpu_ad_oe);
      $display("test handoff done");
   endtask : test_handoff

   task automatic test_isolate();
      // status is registered: show a busy cycle before asking
      @(posedge clk);
      status_in <= 3'h4;
      @(posedge clk);
      iso_mode  <= 1'b1;
      hold_req  <= 1'b1;
      tick(4);
      check("isolate in cycle", 8'h0, iso);
      @(posedge clk);
      status_in <= 3'h7;
      lock_in_n <= 1'b0;
      tick(4);
      check("isolate locked", 8'h0, iso);
      @(posedge clk);
      lock_in_n <= 1'b1;
      n = 0;
      while (iso !== 1'b1) bound("isolate");
      check("iso ack", 8'h3, {ack, cmd_dis});
      tick(1);
      check("ready held", 8'h0, rdy);
      @(posedge clk);
      hold_req <= 1'b0;
      n = 0;
      while (iso !== 1'b0) bound("isolate off");
      check("ack off", 8'h0, ack);
      tick(1);
      check("ready late", 8'h0, rdy);
      tick(1);
      check("ready back", 8'h1, rdy);
      @(posedge clk);
      iso_mode <= 1'b0;
      $display("test isolate done");
   endtask : test_isolate

   task automatic test_priority();
      @(posedge clk);
      bus_busy <= 1'b1;
      b_req_oe <= 2'h2;
      @(posedge clk);
      b_req_oe <= 2'h1;
      @(posedge clk);
      b_req_oe <= 2'h0;
      bus_busy <= 1'b0;
      n = 0;
      while (b_if.cpu_line_oe === 2'h0) bound("first grant");
      check("line 0 first", 8'h1, b_if.cpu_line_oe);
      tick(4);
      check("line 1 held off", 8'h1, grant_b);
      @(posedge clk);
      b_req_oe <= 2'h1;
      @(posedge clk);
      b_req_oe <= 2'h0;
      #1;
      check("one clock handoff", 8'h2, b_if.cpu_line_oe);
      $display("test priority done");
   endtask : test_priority

   task automatic test_slow_handoff();
      @(posedge clk);
      eu_pending <= 1'b1;
      b_req_oe   <= 2'h1;
      @(posedge clk);
      b_req_oe <= 2'h0;
      tick(3);
      check("line 0 held off", 8'h2, grant_b);
      @(posedge clk);
      b_req_oe <= 2'h2;
      @(posedge clk);
      b_req_oe <= 2'h0;
      #1;
      check("not yet", 8'h0, b_if.cpu_line_oe);
      tick(1);
      check("two clock handoff", 8'h1, b_if.cpu_line_oe);
      @(posedge clk);
      eu_pending <= 1'b0;
      b_req_oe   <= 2'h1;
      @(posedge clk);
      b_req_oe <= 2'h0;
      tick(2);
      check("owner cleared", 8'h0, grant_b);
      $display("test slow handoff done");
   endtask : test_slow_handoff

   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      tick(1);
      test_reset();
      test_handoff();
      test_isolate();
      test_priority();
      test_slow_handoff();
      tally_and_finish();
   end
endmodule : local_bus_request_grant_tb
